// >>> acs_cfg.svh
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes a 200 MHz system clock and a byte-addressed register port.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register map.
`define ACS_ADDR_W        8
`define ACS_REG_CTRL      8'h00
`define ACS_REG_STAT      8'h04
`define ACS_CTRL_RESET    16'h0600
`define ACS_CTRL_WMASK    16'h1FFF

// Control word fields.
`define ACS_CLK_HI        12
`define ACS_CLK_LO        10
`define ACS_ACQ_HI        9
`define ACS_ACQ_LO        8
`define ACS_START_BIT     7
`define ACS_BUSY_EN_BIT   6
`define ACS_POWER_BIT     5
`define ACS_MODE_HI       4
`define ACS_MODE_LO       3
`define ACS_TYPE_HI       2
`define ACS_TYPE_LO       0

// Divider terminal counts, one less than the division ratio.
`define ACS_TERM_DIV1     5'h00
`define ACS_TERM_DIV2     5'h01
`define ACS_TERM_DIV4     5'h03
`define ACS_TERM_DIV8     5'h07
`define ACS_TERM_DIV16    5'h0F
`define ACS_TERM_DIV32    5'h1F

// Acquisition lengths in converter clocks.
`define ACS_ACQ_CLKS_0    5'h02
`define ACS_ACQ_CLKS_1    5'h04
`define ACS_ACQ_CLKS_2    5'h08
`define ACS_ACQ_CLKS_3    5'h10

// Bit trials plus write-back, in converter clocks.
`define ACS_CONV_CLKS     5'h13
`define ACS_ONE           5'h01

// Power-up settling time.
`define ACS_SETTLE_NS     5000
`define ACS_CLK_PERIOD_NS 5
`define ACS_SETTLE_CYC    11'((`ACS_SETTLE_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)

`endif

// >>> acs_pkg.sv
// Types shared by the converter control block.
// Assumes acs_cfg.svh carries every numeric constant.
package acs_pkg;

  // Conversion trigger source codes.
  typedef enum logic [2:0] {
    ACS_TRIG_PIN    = 3'b000,
    ACS_TRIG_TIMER_ONE_TRIGGER = 3'b001,
    ACS_TRIG_TIMER_ZERO_TRIGGER = 3'b010,
    ACS_TRIG_SINGLE = 3'b011,
    ACS_TRIG_CONT   = 3'b100,
    ACS_TRIG_LOGIC  = 3'b101
  } acs_trig_t;

  // Input configuration codes.
  typedef enum logic [1:0] {
    ACS_MODE_SINGLE = 2'b00,
    ACS_MODE_DIFF   = 2'b01,
    ACS_MODE_PSEUDO = 2'b10,
    ACS_MODE_RSVD   = 2'b11
  } acs_mode_t;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    ACS_ST_IDLE = 2'b00,
    ACS_ST_ACQ  = 2'b01,
    ACS_ST_CONV = 2'b10
  } acs_state_t;

endpackage

// >>> acs_clk_div.sv
// Converter clock divider: a one-cycle enable every N system clocks.
// Assumes div_code is a registered control field.
`timescale 1ns/100ps
`include "acs_cfg.svh"
module acs_clk_div (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Divider select and tick out.
  input  wire logic [2:0] div_code,
  output logic            tick
);
  import acs_pkg::*;

  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic       next_tick;
  logic [4:0] term;

  // Codes above 101 are undefined; they fall back to the slowest ratio.
  always_comb begin
    case (div_code)
      3'h0:    term = `ACS_TERM_DIV1;
      3'h1:    term = `ACS_TERM_DIV2;
      3'h2:    term = `ACS_TERM_DIV4;
      3'h3:    term = `ACS_TERM_DIV8;
      3'h4:    term = `ACS_TERM_DIV16;
      default: term = `ACS_TERM_DIV32;
    endcase
  end

  // A ratio change mid-count never overshoots since the compare is greater-or-equal.
  always_comb begin
    next_tick = (cnt >= term);
    next_cnt  = next_tick ? 5'h00 : cnt + `ACS_ONE;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt  <= 5'h00;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// >>> acs_edge.sv
// Rising-edge detector for the four trigger inputs.
// Assumes inputs are synchronous to clk; output pulses lag the edge by one cycle.
`timescale 1ns/100ps
module acs_edge (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Levels in, one-cycle pulses out.
  input  wire logic [3:0] level,
  output logic      [3:0] rise
);
  import acs_pkg::*;

  logic [3:0] prev;
  logic [3:0] next_rise;

  // Edge is new level against the previous sample.
  always_comb begin
    next_rise = level & ~prev;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prev <= 4'h0;
      rise <= 4'h0;
    end else begin
      prev <= level;
      rise <= next_rise;
    end
  end

endmodule

// >>> acs_top.sv
// Control word, trigger selection and conversion sequencer for a 12-bit converter.
// Assumes a 200 MHz clock, synchronous triggers and a simple strobe register port.
// Assumes software waits out the power-up settling time before trusting results.
`timescale 1ns/100ps
`include "acs_cfg.svh"

module acs_top (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Register port.
  input  wire logic [`ACS_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  // Trigger sources.
  input  wire logic                   conversion_start_pin,
  input  wire logic                   timer_zero_trigger,
  input  wire logic                   timer_one_trigger,
  input  wire logic                   logic_array_trigger,
  // Analog core control.
  output logic                        converter_base_clock_tick,
  output logic                        power_up,
  output acs_pkg::acs_mode_t          input_mode,
  output logic                        sample_hold,
  output logic                        conversion_active,
  output logic                        result_write,
  // Busy pin.
  output logic                        converter_busy_pin_out,
  output logic                        converter_busy_pin_oe
);
  import acs_pkg::*;

  // Control word, sequencer state and counters.
  logic [15:0] converter_control;
  logic [15:0] next_converter_control;
  acs_state_t  state;
  acs_state_t  next_state;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  logic        cont_run;
  logic        next_cont_run;
  logic [10:0] settle_cnt;
  logic [10:0] next_settle_cnt;
  // Next values of the registered outputs.
  logic [15:0] next_reg_rdata;
  logic        next_sample_hold;
  logic        next_conversion_active;
  logic        next_result_write;
  logic        next_busy_out;
  // Strobes and decoded fields passed between processes.
  logic [3:0]  trig_rise;
  logic        tick;
  logic        start_req;
  logic        launch;
  logic        done;
  logic [2:0]  trig_type;
  logic        start_en;
  logic        powered;
  logic        settled;

  // Acquisition length in converter clocks for a field code.
  // The sequencer loads one less, since it counts down to zero.
  function automatic logic [4:0] acq_clocks(input logic [1:0] code);
    case (code)
      2'h0:    acq_clocks = `ACS_ACQ_CLKS_0;
      2'h1:    acq_clocks = `ACS_ACQ_CLKS_1;
      2'h2:    acq_clocks = `ACS_ACQ_CLKS_2;
      default: acq_clocks = `ACS_ACQ_CLKS_3;
    endcase
  endfunction

  // True when a register strobe hits the given offset.
  function automatic logic hit(input logic [`ACS_ADDR_W-1:0] addr,
                               input logic [`ACS_ADDR_W-1:0] offset);
    hit = (addr == offset);
  endfunction

  // Converter clock enable; every sequencer count advances on it.
  // A ratio change takes effect within one new period; no restart is needed.
  acs_clk_div u_div (
    .clk      (clk),
    .srst     (srst),
    .div_code (converter_control[`ACS_CLK_HI:`ACS_CLK_LO]),
    .tick     (tick)
  );

  // Edge detect on the external trigger levels.
  // Only rising edges count, so a source held high starts one conversion, not many.
  acs_edge u_edge (
    .clk   (clk),
    .srst  (srst),
    .level ({logic_array_trigger, timer_zero_trigger,
             timer_one_trigger, conversion_start_pin}),
    .rise  (trig_rise)
  );

  // Decoded control fields.
  // Named views of the control word keep the processes below readable.
  always_comb begin
    trig_type = converter_control[`ACS_TYPE_HI:`ACS_TYPE_LO];
    start_en  = converter_control[`ACS_START_BIT];
    powered   = converter_control[`ACS_POWER_BIT];
    settled   = (settle_cnt == `ACS_SETTLE_CYC);
  end

  // Trigger source selection; undefined codes never start a conversion.
  // Software types request a start from the code itself and need no edge.
  always_comb begin
    case (trig_type)
      ACS_TRIG_PIN:    start_req = trig_rise[0];
      ACS_TRIG_TIMER_ONE_TRIGGER: start_req = trig_rise[1];
      ACS_TRIG_TIMER_ZERO_TRIGGER: start_req = trig_rise[2];
      ACS_TRIG_SINGLE: start_req = 1'b1;
      ACS_TRIG_CONT:   start_req = 1'b1;
      ACS_TRIG_LOGIC:  start_req = trig_rise[3];
      default:         start_req = 1'b0;
    endcase
  end

  // Starts only from idle, so a trigger mid-conversion is simply lost.
  // Power gates the launch too, so a sleeping core sees at most one cycle of sample strobe.
  always_comb begin
    launch = (state == ACS_ST_IDLE) && powered &&
             ((start_en && start_req) ||
              (cont_run && trig_type == ACS_TRIG_CONT));
  end

  // Continuous run survives a cleared start enable until the type changes.
  // Power-down ends the run as well, so waking the core never restarts it unasked.
  always_comb begin
    next_cont_run = cont_run;
    if (launch && trig_type == ACS_TRIG_CONT) begin
      next_cont_run = 1'b1;
    end
    if (trig_type != ACS_TRIG_CONT || !powered) begin
      next_cont_run = 1'b0;
    end
  end

  // Sequencer: acquisition, then bit trials and write-back, counted in converter clocks.
  // At divide by one with two acquisition clocks: the launch cycle loads the count,
  // two ticks later the bit trials begin, and nineteen ticks after that the
  // sequencer returns to idle as the result strobe goes out.
  // Counting down to zero lets both phases share one comparator.
  // Every count waits for a converter clock tick, so the divider sets the pace.
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    done       = 1'b0;
    case (state)
      ACS_ST_IDLE: begin
        if (launch) begin
          next_state = ACS_ST_ACQ;
          next_cnt   = acq_clocks(converter_control[`ACS_ACQ_HI:`ACS_ACQ_LO]) - `ACS_ONE;
        end
      end
      ACS_ST_ACQ: begin
        if (tick) begin
          if (cnt == 5'h00) begin
            next_state = ACS_ST_CONV;
            next_cnt   = `ACS_CONV_CLKS - `ACS_ONE;
          end else begin
            next_cnt = cnt - `ACS_ONE;
          end
        end
      end
      ACS_ST_CONV: begin
        if (tick) begin
          if (cnt == 5'h00) begin
            next_state = ACS_ST_IDLE;
            done       = 1'b1;
          end else begin
            next_cnt = cnt - `ACS_ONE;
          end
        end
      end
      default: begin
        next_state = ACS_ST_IDLE;
        next_cnt   = 5'h00;
      end
    endcase
    // Powering down abandons a conversion without a result.
    // The core is powered down though its clock tick keeps running, so a half-done result would be garbage.
    if (!powered) begin
      next_state = ACS_ST_IDLE;
      next_cnt   = 5'h00;
      done       = 1'b0;
    end
  end

  // Control word: software write, else hardware reverting a finished single conversion.
  // A write in the same cycle as the revert wins, since it carries a newer command.
  // Bits above the clock field read as zero, since the write mask drops them.
  // A write with the reserved input mode still takes every other field.
  always_comb begin
    next_converter_control = converter_control;
    if (reg_wr && hit(reg_addr, `ACS_REG_CTRL)) begin
      next_converter_control = reg_wdata & `ACS_CTRL_WMASK;
      if (reg_wdata[`ACS_MODE_HI:`ACS_MODE_LO] == ACS_MODE_RSVD) begin
        // The reserved code is refused; the previous input mode stays.
        // The core therefore never sees an undefined input switch setting.
        next_converter_control[`ACS_MODE_HI:`ACS_MODE_LO] =
          converter_control[`ACS_MODE_HI:`ACS_MODE_LO];
      end
    end else if (done && trig_type == ACS_TRIG_SINGLE) begin
      next_converter_control[`ACS_TYPE_HI:`ACS_TYPE_LO] = ACS_TRIG_PIN;
    end
  end

  // Settling timer after power-up, visible to software in the status word.
  // The count stops at its end value, so it cannot wrap and report unsettled later.
  // Nothing in the sequencer waits on it; it only informs software.
  always_comb begin
    next_settle_cnt = settle_cnt;
    if (!powered) begin
      next_settle_cnt = 11'h000;
    end else if (!settled) begin
      next_settle_cnt = settle_cnt + 11'h001;
    end
  end

  // Read data stand only in the cycle after the strobe.
  // Unmapped offsets and idle cycles give zero, which keeps the bus mux simple.
  always_comb begin
    next_reg_rdata = 16'h0000;
    if (reg_rd) begin
      if (hit(reg_addr, `ACS_REG_CTRL)) begin
        next_reg_rdata = converter_control;
      end else if (hit(reg_addr, `ACS_REG_STAT)) begin
        next_reg_rdata = {11'h000, settled, cont_run, state, (state != ACS_ST_IDLE)};
      end
    end
  end

  // Core and pin outputs are registered copies of the next state; the clock tick copies the divider's present tick.
  // Taking them from next values costs some logic depth but saves a cycle of lag.
  // The busy pin follows its enable bit at once, even in mid-conversion.
  always_comb begin
    next_sample_hold       = (next_state == ACS_ST_ACQ);
    next_conversion_active = (next_state != ACS_ST_IDLE);
    next_result_write      = done;
    next_busy_out          = next_converter_control[`ACS_BUSY_EN_BIT] &&
                             (next_state != ACS_ST_IDLE);
  end

  // All state and every output register load here, so every pin leaves a flip-flop.
  // Reset is synchronous, so it needs at least one clock edge while held high.
  always_ff @(posedge clk) begin
    if (srst) begin
      converter_control         <= `ACS_CTRL_RESET;
      state                     <= ACS_ST_IDLE;
      cnt                       <= 5'h00;
      cont_run                  <= 1'b0;
      settle_cnt                <= 11'h000;
      reg_rdata                 <= 16'h0000;
      sample_hold               <= 1'b0;
      conversion_active         <= 1'b0;
      result_write              <= 1'b0;
      converter_busy_pin_out    <= 1'b0;
      converter_busy_pin_oe     <= 1'b0;
      power_up                  <= 1'b0;
      input_mode                <= ACS_MODE_SINGLE;
      converter_base_clock_tick <= 1'b0;
    end else begin
      converter_control         <= next_converter_control;
      state                     <= next_state;
      cnt                       <= next_cnt;
      cont_run                  <= next_cont_run;
      settle_cnt                <= next_settle_cnt;
      reg_rdata                 <= next_reg_rdata;
      sample_hold               <= next_sample_hold;
      conversion_active         <= next_conversion_active;
      result_write              <= next_result_write;
      converter_busy_pin_out    <= next_busy_out;
      converter_busy_pin_oe     <= next_converter_control[`ACS_BUSY_EN_BIT];
      power_up                  <= next_converter_control[`ACS_POWER_BIT];
      input_mode                <= acs_mode_t'(next_converter_control[`ACS_MODE_HI:`ACS_MODE_LO]);
      converter_base_clock_tick <= tick;
    end
  end

endmodule

// >>> acs_trig_src.sv
// Trigger source model: turns a one-cycle fire request into a short high level.
// Assumes fire comes from the bench, one bit per source, synchronous to clk.
`timescale 1ns/100ps
module acs_trig_src #(parameter int DLY = 2) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Requests in, trigger levels out.
  input  wire logic [3:0] fire,
  output logic      [3:0] level
);
  logic [3:0] sr      [0:DLY+2];
  logic [3:0] next_sr [0:DLY+2];

  // Real sources lag the request, so the level rises DLY+1 cycles late and holds three.
  always_comb begin
    next_sr[0] = fire;
    for (int i = 1; i <= DLY + 2; i++) next_sr[i] = sr[i-1];
    level = sr[DLY] | sr[DLY+1] | sr[DLY+2];
  end

  // Shift register of pending requests.
  always_ff @(posedge clk) begin
    for (int i = 0; i <= DLY + 2; i++) sr[i] <= srst ? 4'h0 : next_sr[i];
  end
endmodule

// >>> acs_top_asserts.sv
// Checker for the converter control block, bound to acs_top.
// Assumes one clock clk and a synchronous active-high srst.
`timescale 1ns/100ps
`include "acs_cfg.svh"
module acs_top_asserts (
  // Clock and reset.
  input wire logic                   clk,
  input wire logic                   srst,
  // Register port.
  input wire logic [`ACS_ADDR_W-1:0] reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [15:0]            reg_rdata,
  // Trigger sources.
  input wire logic                   conversion_start_pin,
  input wire logic                   timer_zero_trigger,
  input wire logic                   timer_one_trigger,
  input wire logic                   logic_array_trigger,
  // Analog core control and busy pin.
  input wire logic                   converter_base_clock_tick,
  input wire logic                   power_up,
  input wire acs_pkg::acs_mode_t     input_mode,
  input wire logic                   sample_hold,
  input wire logic                   conversion_active,
  input wire logic                   result_write,
  input wire logic                   converter_busy_pin_out,
  input wire logic                   converter_busy_pin_oe
);
  import acs_pkg::*;
  logic [5:0] n_conv;
  logic [5:0] next_n_conv;

  // Ticks spent in bit trials; cleared whenever the sequencer is idle.
  always_comb begin
    next_n_conv = n_conv;
    if (!conversion_active) next_n_conv = 6'h00;
    else if (!sample_hold && converter_base_clock_tick) next_n_conv = n_conv + 6'h01;
  end

  // Counter register.
  always_ff @(posedge clk) n_conv <= srst ? 6'h00 : next_n_conv;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Bit-trial phase and two idle cycles.
  sequence s_trial;
    conversion_active && !sample_hold;
  endsequence
  sequence s_idle2;
    !conversion_active ##1 !conversion_active;
  endsequence

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  a_busy_pin_gated: assert property (!converter_busy_pin_oe |-> !converter_busy_pin_out)
    else $error("busy driven while disabled");
  a_busy_when_active: assert property (
    converter_busy_pin_oe && conversion_active |-> converter_busy_pin_out)
    else $error("busy low during conversion");
  a_busy_idle_low: assert property (
    converter_busy_pin_oe ##0 s_idle2 |-> !converter_busy_pin_out)
    else $error("busy high while idle");
  a_hold_in_conv: assert property (sample_hold |-> conversion_active)
    else $error("sample hold outside conversion");
  a_trial_length: assert property (
    result_write |-> n_conv >= 6'h13 && n_conv <= 6'h14)
    else $error("bit trial length wrong");
  a_result_pulse: assert property (result_write |=> !result_write)
    else $error("result pulse too long");
  a_no_retrigger: assert property (s_trial |=> !sample_hold)
    else $error("acquisition restarted mid conversion");
  a_start_powered: assert property ($rose(conversion_active) |-> power_up)
    else $error("conversion started while powered down");
  a_power_abort: assert property (!power_up ##1 !power_up |-> !conversion_active)
    else $error("conversion running while powered down");
  a_mode_legal: assert property (input_mode != ACS_MODE_RSVD)
    else $error("reserved input mode shown");
endmodule

bind acs_top acs_top_asserts acs_top_asserts_i (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conversion_start_pin(conversion_start_pin), .timer_zero_trigger(timer_zero_trigger),
  .timer_one_trigger(timer_one_trigger), .logic_array_trigger(logic_array_trigger),
  .converter_base_clock_tick(converter_base_clock_tick), .power_up(power_up),
  .input_mode(input_mode), .sample_hold(sample_hold),
  .conversion_active(conversion_active), .result_write(result_write),
  .converter_busy_pin_out(converter_busy_pin_out),
  .converter_busy_pin_oe(converter_busy_pin_oe));

// >>> test_adc_control_sequencer.sv
// Self-checking bench for the converter control block.
// Assumes acs_top, acs_trig_src and the bound checker are compiled before it.
`timescale 1ns/100ps
`include "acs_cfg.svh"
module test_adc_control_sequencer;
  import acs_pkg::*;
  logic                   clk, srst, reg_wr, reg_rd, rd_q;
  logic                   tick, pwr, sh, act, res, bout, boe;
  logic [`ACS_ADDR_W-1:0] reg_addr;
  logic [15:0]            reg_wdata, reg_rdata;
  logic [3:0]             fire, trg;
  acs_mode_t              imode;
  logic [15:0]            exp_q [$];
  int                     error_cnt, n_checks, act_cnt, sh_cnt;

  acs_top acs_top_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conversion_start_pin(trg[0]), .timer_zero_trigger(trg[1]),
    .timer_one_trigger(trg[2]), .logic_array_trigger(trg[3]),
    .converter_base_clock_tick(tick), .power_up(pwr), .input_mode(imode),
    .sample_hold(sh), .conversion_active(act), .result_write(res),
    .converter_busy_pin_out(bout), .converter_busy_pin_oe(boe));
  acs_trig_src acs_trig_src_i (.clk(clk), .srst(srst), .fire(fire), .level(trg));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // The expected word is queued here and compared by the read monitor.
  task automatic rd(input logic [7:0] a, input logic [15:0] want);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(want);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 4'h0;
  endtask

  task automatic wait_res;
    step;
    for (int i = 0; i < 300 && res !== 1'b1; i++) step;
  endtask

  task automatic tick_gap(output int g);
    step;
    for (int i = 0; i < 80 && tick !== 1'b1; i++) step;
    g = 1;
    step;
    for (int i = 0; i < 80 && tick !== 1'b1; i++) begin
      g++;
      step;
    end
  endtask

  // Flags are start, busy enable, power and the two mode bits.
  function automatic logic [15:0] cw(input logic [2:0] dv, input logic [1:0] aq,
                                     input logic [4:0] flg, input logic [2:0] ty);
    return {3'b000, dv, aq, flg, ty};
  endfunction

  // Read data stand only in the cycle after the strobe, so they are taken there.
  always @(posedge clk) begin
    rd_q <= reg_rd;
    if (rd_q && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
  end

  // Cycles with the conversion running and with the sample held, cleared by the main sequence.
  always @(posedge clk) if (act === 1'b1) act_cnt++;
  always @(posedge clk) if (sh === 1'b1) sh_cnt++;

  // Watchdog sized well above the planned run of about 2000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude;
  end

  initial begin
    logic [2:0] ty [4];
    int c;
    int aq;
    ty = '{3'b000, 3'b010, 3'b001, 3'b101};
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata, fire} = '0;
    srst = 1'b1;
    void'($urandom(32404));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(`ACS_REG_CTRL, `ACS_CTRL_RESET);
    wr(8'h10, 16'($urandom()));
    rd(8'h10, 16'h0000);
    wr(`ACS_REG_CTRL, 16'hFFFF);
    rd(`ACS_REG_CTRL, 16'h1FE7);
    step;
    check(16'({boe, pwr}), 16'h0003);
    check(16'(imode), 16'(ACS_MODE_SINGLE));
    wr(`ACS_REG_CTRL, cw(3'b000, 2'b00, 5'b00110, 3'b111));
    step;
    check(16'(imode), 16'(ACS_MODE_PSEUDO));
    check(16'({boe, pwr}), 16'h0001);
    wr(`ACS_REG_CTRL, cw(3'b000, 2'b00, 5'b00101, 3'b111));
    step;
    check(16'(imode), 16'(ACS_MODE_DIFF));
    repeat (`ACS_SETTLE_CYC) step;
    rd(`ACS_REG_STAT, 16'h0010);
    for (int k = 0; k < 6; k++) begin
      wr(`ACS_REG_CTRL, cw(3'(k), 2'b10, 5'b00100, 3'b111));
      repeat (40) step;
      tick_gap(c);
      check(16'(c), 16'(1 << k));
    end
    for (int k = 0; k < 4; k++) begin
      aq = $urandom_range(3);
      wr(`ACS_REG_CTRL, cw(3'b000, 2'(aq), 5'b11100, ty[k]));
      pulse(4'hF ^ (4'h1 << k));
      repeat (10) step;
      check(16'(act), 16'h0000);
      act_cnt = 0;
      sh_cnt  = 0;
      pulse(4'h1 << k);
      repeat (8) step;
      check(16'(bout), 16'h0001);
      pulse(4'h1 << k);
      wait_res;
      check(16'(res), 16'h0001);
      check(16'(act_cnt), 16'((2 << aq) + 19));
      check(16'(sh_cnt), 16'(2 << aq));
      repeat (30) step;
      check(16'(act), 16'h0000);
    end
    wr(`ACS_REG_CTRL, cw(3'b000, 2'b00, 5'b10100, 3'b011));
    wait_res;
    check(16'(res), 16'h0001);
    rd(`ACS_REG_CTRL, cw(3'b000, 2'b00, 5'b10100, 3'b000));
    wr(`ACS_REG_CTRL, cw(3'b000, 2'b00, 5'b00100, 3'b000));
    pulse(4'h1);
    repeat (10) step;
    check(16'(act), 16'h0000);
    wr(`ACS_REG_CTRL, cw(3'b000, 2'b00, 5'b10100, 3'b100));
    wait_res;
    wr(`ACS_REG_CTRL, cw(3'b000, 2'b00, 5'b00100, 3'b100));
    wait_res;
    check(16'(res), 16'h0001);
    wr(`ACS_REG_CTRL, cw(3'b000, 2'b00, 5'b00000, 3'b100));
    repeat (40) step;
    check(16'({act, pwr}), 16'h0000);
    repeat (3) step;
    conclude;
  end
endmodule
